// [logic/pae_regs.sv]
// Expansion status and vendor configuration management registers.
`timescale 1ns/10ps
`default_nettype none

module pae_regs
  import pae_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  input  wire logic        i_pd_fault,
  input  wire logic        i_page_rx,
  input  wire logic        i_partner_np_capable,
  input  wire logic        i_partner_an_capable,
  input  wire logic        i_strap_repeater,
  input  wire logic        i_strap_rmii,
  input  wire logic        i_line_link_100,
  input  wire logic        i_speed_100,
  input  wire logic        i_full_duplex,
  input  wire logic        i_collision,
  input  wire logic        i_energy_detect,
  output logic             o_coding_bypass,
  output logic             o_scrambler_bypass,
  output logic             o_alignment_bypass,
  output logic             o_adaptation_ok_bypass,
  output logic             o_repeater_mode,
  output logic             o_tx_100_mode,
  output logic             o_rmii_mode,
  output logic             o_preamble_suppress,
  output logic             o_sleep,
  output logic             o_remote_loopback,
  output logic             o_link_ok_100,
  output logic             o_speed_led,
  output logic             o_fdx_col_led,
  output logic             o_power_reduced,
  output logic             o_sm_reset
);

  localparam int STATE_MACHINE_RESET_LIM = STATE_MACHINE_RESET_CYC + 3;

  function automatic logic f_hit(input logic [4:0] addr,
                                 input logic [4:0] off);
    f_hit = (addr == off);
  endfunction : f_hit

  logic        rd_exp;
  logic        rd_cfg;
  logic        wr_cfg;
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic        strap_pend_r;
  logic        np_r;
  logic        an_r;
  logic [1:0]  lh_evt;
  logic [1:0]  lh_val;
  logic        parallel_detect_fault_flag;
  logic        page;
  logic [15:0] exp_word;
  logic        seq_start;
  logic        seq_done;

  assign rd_exp = i_reg_rd && f_hit(i_reg_addr, ADDR_EXP);
  assign rd_cfg = i_reg_rd && f_hit(i_reg_addr, ADDR_CFG);
  assign wr_cfg = i_reg_wr && f_hit(i_reg_addr, ADDR_CFG);

  // Latched-high event flags, parallel fault in bit 1, page in bit 0.
  assign lh_evt = {i_pd_fault, i_page_rx};

  generate
    for (genvar g = 0; g < 2; g++) begin : gen_lh
      logic flag_r;
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          flag_r <= 1'b0;
        end else begin
          // An event in the read cycle keeps the flag set.
          flag_r <= lh_evt[g] | (flag_r & ~rd_exp);
        end
      end
      assign lh_val[g] = flag_r;
    end
  endgenerate

  assign parallel_detect_fault_flag  = lh_val[1];
  assign page = lh_val[0];

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      np_r <= 1'b0;
      an_r <= 1'b0;
    end else begin
      np_r <= i_partner_np_capable;
      an_r <= i_partner_an_capable;
    end
  end

  always_comb begin
    exp_word           = EXP_RST;
    exp_word[EXP_PDF]  = parallel_detect_fault_flag;
    exp_word[EXP_LPNP] = np_r;
    exp_word[EXP_NP]   = 1'b0;
    exp_word[EXP_PAGE] = page;
    exp_word[EXP_LPAN] = an_r;
  end

  // Straps are sampled in the first cycle after reset is released.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      strap_pend_r <= 1'b1;
    end else begin
      strap_pend_r <= 1'b0;
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    if (strap_pend_r) begin
      cfg_nxt[CFG_REP]  = i_strap_repeater;
      cfg_nxt[CFG_RMII] = i_strap_rmii;
    end
    if (wr_cfg) begin
      cfg_nxt = (i_reg_wdata & CFG_WMASK) | CFG_FIXED1;
    end
    cfg_nxt[CFG_STATE_MACHINE_RESET] = (wr_cfg & i_reg_wdata[CFG_STATE_MACHINE_RESET]) |
                         (cfg_r[CFG_STATE_MACHINE_RESET] & ~seq_done);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cfg_r <= CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // A write of one to reset, or a wake from sleep, restarts the PHY.
  assign seq_start = wr_cfg & (i_reg_wdata[CFG_STATE_MACHINE_RESET] |
                     (cfg_r[CFG_SLEEP] & ~i_reg_wdata[CFG_SLEEP]));

  pae_seq u_seq (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_start    (seq_start),
    .o_sm_reset (o_sm_reset),
    .o_done     (seq_done)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_reg_rdata  <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (rd_exp) begin
        o_reg_rdata <= exp_word;
      end else if (rd_cfg) begin
        o_reg_rdata <= cfg_r;
      end else begin
        o_reg_rdata <= 16'h0000;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_coding_bypass        <= 1'b0;
      o_scrambler_bypass     <= 1'b0;
      o_alignment_bypass     <= 1'b0;
      o_adaptation_ok_bypass <= 1'b0;
      o_repeater_mode        <= 1'b0;
      o_tx_100_mode          <= 1'b0;
      o_rmii_mode            <= 1'b0;
      o_preamble_suppress    <= 1'b0;
      o_sleep                <= 1'b0;
      o_remote_loopback      <= 1'b0;
    end else begin
      o_coding_bypass        <= cfg_r[CFG_CODE];
      o_scrambler_bypass     <= cfg_r[CFG_SCR];
      o_alignment_bypass     <= cfg_r[CFG_ALIGN];
      o_adaptation_ok_bypass <= cfg_r[CFG_ADPOK];
      o_repeater_mode        <= cfg_r[CFG_REP];
      o_tx_100_mode          <= cfg_r[CFG_TX];
      o_rmii_mode            <= cfg_r[CFG_RMII];
      o_preamble_suppress    <= cfg_r[CFG_PRE];
      o_sleep                <= cfg_r[CFG_SLEEP];
      o_remote_loopback      <= cfg_r[CFG_RLOOP];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_link_ok_100   <= 1'b0;
      o_speed_led     <= 1'b0;
      o_fdx_col_led   <= 1'b0;
      o_power_reduced <= 1'b0;
    end else begin
      o_link_ok_100   <= cfg_r[CFG_FLINK] | i_line_link_100;
      o_speed_led     <= i_speed_100 & ~cfg_r[CFG_SPLED];
      o_fdx_col_led   <= i_full_duplex |
                         (cfg_r[CFG_COLLED] & i_collision);
      o_power_reduced <= cfg_r[CFG_APD] & ~i_energy_detect &
                         ~cfg_r[CFG_SLEEP];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rstn);

  property p_exp_rsv;
    rd_exp |=> o_reg_rdata[15:EXP_RSV_LSB] == 11'h000;
  endproperty
  a_exp_rsv: assert property (p_exp_rsv)
    else $error("Expansion reserved bits not zero.");

  property p_pdf_hold;
    (parallel_detect_fault_flag && !rd_exp) |=> parallel_detect_fault_flag;
  endproperty
  a_pdf_hold: assert property (p_pdf_hold)
    else $error("Parallel fault flag dropped before read.");

  property p_pdf_read;
    (i_pd_fault ##1 rd_exp) |=> o_reg_rdata[EXP_PDF];
  endproperty
  a_pdf_read: assert property (p_pdf_read)
    else $error("Parallel fault not reported on read.");

  property p_lpnp;
    rd_exp |=> o_reg_rdata[EXP_LPNP] == $past(i_partner_np_capable, 2);
  endproperty
  a_lpnp: assert property (p_lpnp)
    else $error("Partner next page bit wrong.");

  property p_np_zero;
    rd_exp |=> !o_reg_rdata[EXP_NP];
  endproperty
  a_np_zero: assert property (p_np_zero)
    else $error("Local next page bit not zero.");

  property p_page_clr;
    (rd_exp && !i_page_rx) |=> !page;
  endproperty
  a_page_clr: assert property (p_page_clr)
    else $error("Page flag not cleared by read.");

  property p_page_set;
    i_page_rx |=> page;
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("Page flag not set on event.");

  property p_lpan;
    rd_exp |=> o_reg_rdata[EXP_LPAN] == $past(i_partner_an_capable, 2);
  endproperty
  a_lpan: assert property (p_lpan)
    else $error("Partner autoneg bit wrong.");

  property p_strap;
    strap_pend_r && !wr_cfg |=>
      cfg_r[CFG_REP] == $past(i_strap_repeater) &&
      cfg_r[CFG_RMII] == $past(i_strap_rmii);
  endproperty
  a_strap: assert property (p_strap)
    else $error("Strap values not latched.");

  property p_link;
    cfg_r[CFG_FLINK] |=> o_link_ok_100;
  endproperty
  a_link: assert property (p_link)
    else $error("Forced link not reported good.");

  property p_spled;
    cfg_r[CFG_SPLED] |=> !o_speed_led;
  endproperty
  a_spled: assert property (p_spled)
    else $error("Speed LED not suppressed.");

  property p_col_led;
    (cfg_r[CFG_COLLED] && i_collision) |=> o_fdx_col_led;
  endproperty
  a_col_led: assert property (p_col_led)
    else $error("Collision not shown on duplex LED.");

  property p_apd_off;
    !cfg_r[CFG_APD] |=> !o_power_reduced;
  endproperty
  a_apd_off: assert property (p_apd_off)
    else $error("Power reduced while auto power-down disabled.");

  property p_state_machine_reset_clear;
    (wr_cfg && i_reg_wdata[CFG_STATE_MACHINE_RESET]) |=>
      cfg_r[CFG_STATE_MACHINE_RESET] ##[1:STATE_MACHINE_RESET_LIM] !cfg_r[CFG_STATE_MACHINE_RESET];
  endproperty
  a_state_machine_reset_clear: assert property (p_state_machine_reset_clear)
    else $error("State machine reset bit did not self clear.");

  property p_wake;
    (wr_cfg && cfg_r[CFG_SLEEP] && !i_reg_wdata[CFG_SLEEP]) |=>
      ##1 o_sm_reset;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake from sleep did not reset state machines.");

  property p_ro_bit;
    wr_cfg |=> cfg_r[CFG_RSV9];
  endproperty
  a_ro_bit: assert property (p_ro_bit)
    else $error("Read-only configuration bit changed.");

  c_page_read: cover property (page ##1 rd_exp ##1 !page);
  c_state_machine_reset: cover property ($rose(o_sm_reset) ##[1:STATE_MACHINE_RESET_LIM] seq_done);
  c_wake: cover property (o_sleep ##[1:8] !o_sleep);
  c_pdf_race: cover property (parallel_detect_fault_flag && rd_exp && i_pd_fault);

endmodule : pae_regs

`default_nettype wire

// [logic/pae_pkg.sv]
// Constants shared by the expansion and configuration register bank.
`default_nettype none

package pae_pkg;

  localparam logic [4:0]  ADDR_EXP      = 5'h06;
  localparam logic [4:0]  ADDR_CFG      = 5'h10;

  localparam int          EXP_PDF       = 4;
  localparam int          EXP_LPNP      = 3;
  localparam int          EXP_NP        = 2;
  localparam int          EXP_PAGE      = 1;
  localparam int          EXP_LPAN      = 0;
  localparam int          EXP_RSV_LSB   = 5;
  localparam logic [15:0] EXP_RST       = 16'h0000;

  localparam int          CFG_CODE      = 15;
  localparam int          CFG_SCR       = 14;
  localparam int          CFG_ALIGN     = 13;
  localparam int          CFG_ADPOK     = 12;
  localparam int          CFG_REP       = 11;
  localparam int          CFG_TX        = 10;
  localparam int          CFG_RSV9      = 9;
  localparam int          CFG_RMII      = 8;
  localparam int          CFG_FLINK     = 7;
  localparam int          CFG_SPLED     = 6;
  localparam int          CFG_COLLED    = 5;
  localparam int          CFG_APD       = 4;
  localparam int          CFG_STATE_MACHINE_RESET     = 3;
  localparam int          CFG_PRE       = 2;
  localparam int          CFG_SLEEP     = 1;
  localparam int          CFG_RLOOP     = 0;
  localparam logic [15:0] CFG_RST       = 16'h1614;
  localparam logic [15:0] CFG_WMASK     = 16'hFDFF;
  localparam logic [15:0] CFG_FIXED1    = 16'h0200;

  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STATE_MACHINE_RESET_TIME_NS = 200;
  localparam int          STATE_MACHINE_RESET_CYC     =
    (STATE_MACHINE_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    PAE_SQ_IDLE,
    PAE_SQ_HOLD
  } pae_seq_type;

endpackage : pae_pkg

`default_nettype wire

// [logic/pae_seq.sv]
// State machine reset sequencer that holds reset for a fixed time.
`timescale 1ns/10ps
`default_nettype none

module pae_seq
  import pae_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_start,
  output logic      o_sm_reset,
  output logic      o_done
);

  localparam int SEQ_LIM = STATE_MACHINE_RESET_CYC + 1;

  pae_seq_type state_r;
  logic [7:0]  cnt_r;
  logic [7:0]  hi_cnt_r;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_r    <= PAE_SQ_IDLE;
      cnt_r      <= 8'h00;
      o_sm_reset <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_r)
        PAE_SQ_IDLE: begin
          if (i_start) begin
            state_r    <= PAE_SQ_HOLD;
            cnt_r      <= 8'(STATE_MACHINE_RESET_CYC - 1);
            o_sm_reset <= 1'b1;
          end
        end
        PAE_SQ_HOLD: begin
          if (i_start) begin
            cnt_r <= 8'(STATE_MACHINE_RESET_CYC - 1);
          end else if (cnt_r == 8'h00) begin
            state_r    <= PAE_SQ_IDLE;
            o_sm_reset <= 1'b0;
            o_done     <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          state_r    <= PAE_SQ_IDLE;
          o_sm_reset <= 1'b0;
        end
      endcase
    end
  end

  // Counts cycles with the reset output high, for the length check.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hi_cnt_r <= 8'h00;
    end else if (!o_sm_reset) begin
      hi_cnt_r <= 8'h00;
    end else if (hi_cnt_r != 8'hFF) begin
      hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end

  property p_seq_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    $fell(o_sm_reset) |-> hi_cnt_r >= 8'(STATE_MACHINE_RESET_CYC);
  endproperty
  a_seq_hold: assert property (p_seq_hold)
    else $error("State machine reset too short.");

  property p_seq_done;
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(o_sm_reset) |-> ##[1:SEQ_LIM] o_done;
  endproperty
  a_seq_done: assert property (p_seq_done)
    else $error("State machine reset never completed.");

endmodule : pae_seq

`default_nettype wire

// [test/pae_mgmt_model.sv]
// Management controller model that issues register reads and writes.
`timescale 1ns/10ps
`default_nettype none

module pae_mgmt_model (
  input  wire logic        i_clk,
  output logic [4:0]       o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_wdata
);
  initial begin
    o_addr  = 5'h1F;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 16'h0000;
  end

  // Released lines carry inverted values so nothing stale looks valid.
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : write

  task automatic read(input logic [4:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
  endtask : read
endmodule : pae_mgmt_model

`default_nettype wire

// [test/test_pae_regs.sv]
// Self-checking testbench for the expansion and configuration registers.
`timescale 1ns/10ps
`default_nettype none

module test_pae_regs
  import pae_pkg::*;
;
  logic        clk;
  logic        rstn = 1'b0;
  logic [4:0]  addr;
  logic        wr;
  logic        rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        parallel_detect_fault_flag = 1'b0;
  logic        pgr = 1'b0;
  logic        lpnp = 1'b0;
  logic        lpan = 1'b0;
  logic        srep;
  logic        srmii;
  logic        lk = 1'b0;
  logic        sp = 1'b0;
  logic        fd = 1'b0;
  logic        co = 1'b0;
  logic        en = 1'b1;
  logic [9:0]  cpy;
  logic        link;
  logic        sled;
  logic        fled;
  logic        pred;
  logic        smr;
  logic [15:0] cfg_e;
  logic [15:0] w;
  logic [15:0] ec;
  logic [15:0] expq[$];
  int          error_cnt = 0;
  int          checks = 0;

  pae_regs i_pae_regs (
    .i_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_pd_fault(parallel_detect_fault_flag), .i_page_rx(pgr),
    .i_partner_np_capable(lpnp), .i_partner_an_capable(lpan),
    .i_strap_repeater(srep), .i_strap_rmii(srmii), .i_line_link_100(lk),
    .i_speed_100(sp), .i_full_duplex(fd), .i_collision(co),
    .i_energy_detect(en), .o_coding_bypass(cpy[9]),
    .o_scrambler_bypass(cpy[8]), .o_alignment_bypass(cpy[7]),
    .o_adaptation_ok_bypass(cpy[6]), .o_repeater_mode(cpy[5]),
    .o_tx_100_mode(cpy[4]), .o_rmii_mode(cpy[3]),
    .o_preamble_suppress(cpy[2]), .o_sleep(cpy[1]),
    .o_remote_loopback(cpy[0]), .o_link_ok_100(link), .o_speed_led(sled),
    .o_fdx_col_led(fled), .o_power_reduced(pred), .o_sm_reset(smr)
  );

  pae_mgmt_model i_pae_mgmt_model (
    .i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic give_verdict();
    if (expq.size() != 0) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: reads left unanswered", $time);
    end
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    expq.push_back(e);
    i_pae_mgmt_model.read(a);
  endtask : rchk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  // Compares the mode copies and the derived status outputs.
  task automatic cout();
    ec = 16'({cfg_e[15:10], cfg_e[8], cfg_e[2:0]});
    chk(16'(cpy), ec);
    ec = 16'({cfg_e[7] | lk, sp & ~cfg_e[6], fd | (cfg_e[5] & co),
              cfg_e[4] & ~en & ~cfg_e[1]});
    chk(16'({link, sled, fled, pred}), ec);
  endtask : cout

  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: unexpected read data", $time);
      end else begin
        chk(rdata, expq.pop_front());
      end
    end
  end

  initial begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout", $time);
    give_verdict();
  end

  initial begin
    void'($urandom(80685));
    {srep, srmii} <= 2'($urandom);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wt(2);
    cfg_e = CFG_RST | (16'(srep) << CFG_REP) | (16'(srmii) << CFG_RMII);
    rchk(ADDR_CFG, cfg_e);
    rchk(ADDR_EXP, EXP_RST);
    rchk(5'h01, 16'h0000);
    wt(0);
    cout();
    $display("Test reset defaults done");

    i_pae_mgmt_model.write(ADDR_EXP, 16'hFFFF);
    rchk(ADDR_EXP, EXP_RST);
    $display("Test read-only write done");

    @(posedge clk);
    parallel_detect_fault_flag <= 1'b1;
    pgr <= 1'b1;
    lpnp <= 1'b1;
    lpan <= 1'b1;
    @(posedge clk);
    parallel_detect_fault_flag <= 1'b0;
    pgr <= 1'b0;
    rchk(ADDR_EXP, 16'h001B);
    rchk(ADDR_EXP, 16'h0009);
    @(posedge clk);
    lpnp <= 1'b0;
    lpan <= 1'b0;
    rchk(ADDR_EXP, 16'h0000);
    @(posedge clk);
    parallel_detect_fault_flag <= 1'b1;
    rchk(ADDR_EXP, 16'h0010);
    parallel_detect_fault_flag <= 1'b0;
    rchk(ADDR_EXP, 16'h0010);
    rchk(ADDR_EXP, 16'h0000);
    $display("Test latching flags done");

    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'hFFF5 : 16'($urandom) & ~16'h000A;
      @(posedge clk);
      {lk, sp, fd, co, en} <= 5'($urandom);
      i_pae_mgmt_model.write(ADDR_CFG, w);
      cfg_e = (w & CFG_WMASK) | CFG_FIXED1;
      rchk(ADDR_CFG, cfg_e);
      wt(1);
      cout();
    end
    $display("Test configuration writes done");

    i_pae_mgmt_model.write(ADDR_CFG, cfg_e | 16'h0008);
    wt(0);
    chk(16'(smr), 16'h0001);
    rchk(ADDR_CFG, cfg_e | 16'h0008);
    wt(17);
    chk(16'(smr), 16'h0001);
    wt(3);
    chk(16'(smr), 16'h0000);
    rchk(ADDR_CFG, cfg_e);
    $display("Test state machine reset done");

    @(posedge clk);
    en <= 1'b0;
    cfg_e = cfg_e | 16'h0012;
    i_pae_mgmt_model.write(ADDR_CFG, cfg_e);
    wt(2);
    cout();
    cfg_e = cfg_e & ~16'h0002;
    i_pae_mgmt_model.write(ADDR_CFG, cfg_e);
    wt(0);
    chk(16'(smr), 16'h0001);
    rchk(ADDR_CFG, cfg_e);
    wt(1);
    cout();
    $display("Test sleep and wake done");

    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule : test_pae_regs

`default_nettype wire
